// [hdl/led_driver_protection_control.sv]
// switching sequence and protection control for the led driver
`timescale 1ns/10ps
module led_driver_protection_control
    import led_ctrl_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int SHORT_BLANK_CYCLES = SHORT_BLANK_CYC,
    parameter int CM_CYCLES = CM_CYC
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // analog front end
    input wire cmp_s cmp_i,
    input wire logic [CODE_W-1:0] output_sense_pin_i,
    input wire logic [CODE_W-1:0] compensation_node_i,
    // power stage and supply
    output logic gate_o,
    output logic hv_supply_o,
    output logic current_mode_o,
    output logic cl_low_o,
    // status
    output logic otp_o,
    output fault_s fault_o
);

    sw_state_e state_r, state_nxt;
    logic [TMR_W-1:0] timer_r;
    logic [TON_W-1:0] ton_r;
    logic [2:0] short_cnt_r;
    logic gate_r, hv_supply_r, cm_r, cl_low_r, otp_r;
    logic first_r, cs_seen_r, period_r;
    fault_s fault_r;
    logic osc_wrap;

    // decoded conditions
    wire running = (state_r == ST_ON) || (state_r == ST_WAIT);
    wire cs_limit_hit = cl_low_r ? cmp_i.cs_lim_lo : cmp_i.cs_lim_hi;
    wire ton_cap = ton_r >= TON_W'(TON_MAX_CYC);
    wire ton_comp = ton_r >= {1'b0, compensation_node_i};
    wire on_done = cs_limit_hit || ton_cap || (!cm_r && ton_comp);
    wire period_up = period_r || osc_wrap;
    wire start_ok = period_up && !cmp_i.diode_cond && !otp_r;
    wire cyc_start = (state_r == ST_WAIT) && start_ok;
    wire cs_seen_now = cs_seen_r || cmp_i.cs_min;
    wire short_armed = timer_r >= TMR_W'(SHORT_BLANK_CYCLES);
    wire hold_on = timer_r < TMR_W'(HOLD_CYCLES);

    // protection trips
    wire ocp_hit = running && cmp_i.cs_ocp;
    wire ovp_hit = (state_r == ST_WAIT)
        && (cmp_i.vdd_ovp || cmp_i.osense_ovp);
    wire rshort_hit = (state_r == ST_ON) && on_done && !cs_seen_now
        && (first_r || (!cm_r && cmp_i.vin_60));
    wire short_hit = cyc_start && cmp_i.osense_low && short_armed
        && (short_cnt_r >= SHORT_CYCLES - 3'h1);
    wire trip = ocp_hit || ovp_hit || rshort_hit || short_hit;

    // switching sequence; undervoltage outranks everything
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF:
            begin
                if (cmp_i.vdd_on)
                    state_nxt = ST_WAIT;
            end
            ST_ON:
            begin
                if (trip)
                    state_nxt = ST_FAULT;
                else if (on_done || otp_r)
                    state_nxt = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (trip)
                    state_nxt = ST_FAULT;
                else if (start_ok)
                    state_nxt = ST_ON;
            end
            ST_FAULT:
            begin
                state_nxt = ST_FAULT;
            end
        endcase
        if (cmp_i.vdd_off)
            state_nxt = ST_OFF;
    end

    // period restarts from each turn-on so bcm stretches it honestly
    phase_osc u_osc (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(running),
        .restart_i(cyc_start),
        .step_i(output_sense_pin_i),
        .wrap_o(osc_wrap)
    );

    // state, gate and the startup timer
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_r <= ST_OFF;
            gate_r <= 1'b0;
            timer_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            gate_r <= (state_nxt == ST_ON);
            if (state_nxt == ST_OFF)
                timer_r <= '0;
            else if (hold_on)
                timer_r <= timer_r + TMR_W'(1);
        end
    end

    // startup mode, current limit select and supply hold
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cm_r <= 1'b1;
            cl_low_r <= 1'b0;
            hv_supply_r <= 1'b1;
        end
        else
        begin
            cm_r <= timer_r < TMR_W'(CM_CYCLES);
            cl_low_r <= cmp_i.osense_low;
            if (state_r == ST_OFF || !hold_on)
                hv_supply_r <= (state_r == ST_OFF);
            else if (cmp_i.vdd_hold_lo)
                hv_supply_r <= 1'b1;
            else if (cmp_i.vdd_hold_hi)
                hv_supply_r <= 1'b0;
        end
    end

    // thermal hold with hysteresis, heating wins
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            otp_r <= 1'b0;
        else if (cmp_i.temp_hot)
            otp_r <= 1'b1;
        else if (cmp_i.temp_cool)
            otp_r <= 1'b0;
    end

    // per-cycle bookkeeping: on-time, period, sense seen, first cycle
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || state_r == ST_OFF)
        begin
            ton_r <= '0;
            period_r <= 1'b0;
            cs_seen_r <= 1'b0;
            first_r <= 1'b1;
        end
        else
        begin
            ton_r <= (state_r == ST_ON) ? ton_r + TON_W'(1) : '0;
            period_r <= !cyc_start && period_up;
            cs_seen_r <= !cyc_start && (cs_seen_r
                || (state_r == ST_ON && cmp_i.cs_min));
            if (state_r == ST_ON && state_nxt != ST_ON)
                first_r <= 1'b0;
        end
    end

    // consecutive low output sense cycles, saturating
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || state_r == ST_OFF)
            short_cnt_r <= '0;
        else if (cyc_start && !cmp_i.osense_low)
            short_cnt_r <= '0;
        else if (cyc_start && short_cnt_r < SHORT_CYCLES)
            short_cnt_r <= short_cnt_r + 3'h1;
    end

    // trip causes stay until the next undervoltage
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || cmp_i.vdd_off)
            fault_r <= '0;
        else if (state_r != ST_FAULT)
        begin
            fault_r.short_led_protect <= short_hit;
            fault_r.ovp <= ovp_hit;
            fault_r.sense_resistor_short_protect <= rshort_hit;
            fault_r.ocp <= ocp_hit;
        end
    end

    // outputs straight from flops
    assign gate_o = gate_r;
    assign hv_supply_o = hv_supply_r;
    assign current_mode_o = cm_r;
    assign cl_low_o = cl_low_r;
    assign otp_o = otp_r;
    assign fault_o = fault_r;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_uvlo;
        cmp_i.vdd_off |=> state_r == ST_OFF && !gate_r;
    endproperty
    a_uvlo: assert property (p_uvlo)
        else $error("gate active after undervoltage");

    property p_ocp;
        running && cmp_i.cs_ocp && !cmp_i.vdd_off
            |=> state_r == ST_FAULT && !gate_r ##1 fault_r.ocp;
    endproperty
    a_ocp: assert property (p_ocp)
        else $error("over-current did not stop the gate");

    property p_ovp;
        state_r == ST_WAIT && (cmp_i.vdd_ovp || cmp_i.osense_ovp)
            && !cmp_i.vdd_off |=> state_r == ST_FAULT;
    endproperty
    a_ovp: assert property (p_ovp)
        else $error("over-voltage in off-time not tripped");

    property p_short_count;
        $rose(fault_r.short_led_protect)
            |-> $past(short_cnt_r) >= 3'h3 && $past(cmp_i.osense_low);
    endproperty
    a_short_count: assert property (p_short_count)
        else $error("short-led tripped before four low cycles");

    property p_short_blank;
        $rose(fault_r.short_led_protect)
            |-> $past(timer_r) >= TMR_W'(SHORT_BLANK_CYCLES);
    endproperty
    a_short_blank: assert property (p_short_blank)
        else $error("short-led tripped inside blanking");

    property p_cl_low;
        state_r == ST_ON && cl_low_r && cmp_i.cs_lim_lo
            && !cmp_i.cs_lim_hi |=> !gate_r;
    endproperty
    a_cl_low: assert property (p_cl_low)
        else $error("low current limit not applied");

    property p_bcm;
        $rose(gate_r) |-> !$past(cmp_i.diode_cond) && !$past(otp_r);
    endproperty
    a_bcm: assert property (p_bcm)
        else $error("turn-on during diode conduction");

    property p_fault_hold;
        state_r == ST_FAULT && !cmp_i.vdd_off
            |=> state_r == ST_FAULT && !gate_r;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("left fault without undervoltage");

    property p_otp;
        otp_r |=> !gate_r;
    endproperty
    a_otp: assert property (p_otp)
        else $error("gate on while over-temperature");

    property p_cm_end;
        $fell(cm_r) |-> $past(timer_r) == TMR_W'(CM_CYCLES);
    endproperty
    a_cm_end: assert property (p_cm_end)
        else $error("current mode ended at the wrong time");

    property p_hold;
        state_r != ST_OFF && hold_on && cmp_i.vdd_hold_lo
            |=> hv_supply_r;
    endproperty
    a_hold: assert property (p_hold)
        else $error("supply hold not engaged at low supply");

    c_short: cover property ($rose(fault_r.short_led_protect));
    c_rshort: cover property ($rose(fault_r.sense_resistor_short_protect));
    c_bcm: cover property (period_r && cmp_i.diode_cond ##1 $rose(gate_r));
    c_otp: cover property ($fell(otp_r) ##[1:1000] $rose(gate_r));

endmodule

// [hdl/led_ctrl_pkg.sv]
// constants, types and states shared by the led driver control logic
//
// Overview of operation
// - Frequency tracks output sense linearly; the period grows as it falls.
// - If the diode outlasts the period, the next cycle waits for its end.
// - Output sense below 0.3 V drops the current limit from 1.0 V to 0.2 V.
// - Four low output-sense cycles in a row trip short-LED; a good one resets.
// - For 250 ms after turn-on the startup source holds supply in 13-19 V.
// - Short-LED detection is ignored for the first 15 ms after turn-on.
// - Supply or output-sense over-voltage in off-time trips protection.
// - Current sense under 0.1 V all through the first cycle stops the gate.
// - After 20 ms, sense under 0.1 V with line above 60% of peak stops it.
// - Operation starts at 16 V supply and locks out below 7.75 V.
// - Current sense above 1.35 V, open resistor included, stops switching.
// - Above 150 C the drive stops until the die has cooled by 10 C.
// - In voltage mode, on-time follows the compensation node, which dimming may move.
// - The first 20 ms after turn-on run in current mode, then voltage mode.
package led_ctrl_pkg;

    // clock and startup timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int HOLD_MS = 250;
    localparam int SHORT_BLANK_MS = 15;
    localparam int CM_MS = 20;
    localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
    localparam int SHORT_BLANK_CYC = SHORT_BLANK_MS * CYC_PER_MS;
    localparam int CM_CYC = CM_MS * CYC_PER_MS;
    localparam int TMR_W = 23;

    // maximum on-time, longest time so rounded down
    localparam int TON_MAX_NS = 13500;
    localparam int TON_MAX_CYC = (TON_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int TON_W = 9;

    // frequency accumulator and short-led count
    localparam int PH_W = 16;
    localparam int CODE_W = 8;
    localparam logic [CODE_W-1:0] STEP_MIN = 8'h01;
    localparam logic [2:0] SHORT_CYCLES = 3'h4;

    // switching sequence states
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ON = 2'b01,
        ST_WAIT = 2'b10,
        ST_FAULT = 2'b11
    } sw_state_e;

    // comparator outputs from the analog front end
    typedef struct packed {
        logic vdd_on;       // supply at or above 16 V
        logic vdd_off;      // supply below 7.75 V
        logic vdd_hold_lo;  // supply at or below 13 V
        logic vdd_hold_hi;  // supply at or above 19 V
        logic vdd_ovp;      // supply over-voltage
        logic osense_ovp;   // output sense over-voltage
        logic osense_low;   // output sense below 0.3 V
        logic cs_lim_hi;    // current sense above 1.0 V
        logic cs_lim_lo;    // current sense above 0.2 V
        logic cs_ocp;       // current sense above 1.35 V
        logic cs_min;       // current sense above 0.1 V
        logic vin_60;       // input above 60% of its peak
        logic temp_hot;     // junction above 150 C
        logic temp_cool;    // junction below 140 C
        logic diode_cond;   // secondary diode still conducting
    } cmp_s;

    // latched cause of a protection trip
    typedef struct packed {
        logic short_led_protect;
        logic ovp;
        logic sense_resistor_short_protect;
        logic ocp;
    } fault_s;

endpackage

// [hdl/phase_osc.sv]
// frequency accumulator that marks the end of each switching period
`timescale 1ns/10ps
module phase_osc
    import led_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // control
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [CODE_W-1:0] step_i,
    // period end
    output logic wrap_o
);

    logic [PH_W-1:0] acc_r;
    logic [PH_W:0] sum;
    logic [CODE_W-1:0] step;

    // zero code would freeze the period, so clamp to one
    assign step = (step_i < STEP_MIN) ? STEP_MIN : step_i;
    assign sum = {1'b0, acc_r} + {{(PH_W+1-CODE_W){1'b0}}, step};

    // carry out rate is proportional to the step code
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || !run_i || restart_i)
        begin
            acc_r <= '0;
            wrap_o <= 1'b0;
        end
        else
        begin
            acc_r <= sum[PH_W-1:0];
            wrap_o <= sum[PH_W];
        end
    end

endmodule

// [verification/flyback_stage.sv]
// behavioural flyback stage seen through current and diode comparators
`timescale 1ns/10ps
module flyback_stage
(
    // clock and gate drive
    input wire logic clk_i,
    input wire logic gate_i,
    // 0 normal, 1 sense resistor shorted, 2 sense resistor open
    input wire logic [1:0] mode_i,
    input wire logic [7:0] diode_len_i,
    // comparator levels
    output logic cs_min_o,
    output logic cs_lim_lo_o,
    output logic cs_lim_hi_o,
    output logic cs_ocp_o,
    output logic diode_cond_o
);
    logic [8:0] on_r = 9'h000;
    logic [7:0] dis_r = 8'h00;
    logic ramp_w;
    logic open_w;

    // current ramps while on; diode drains stored energy after turn-off
    always_ff @(posedge clk_i)
    begin
        on_r <= gate_i ? on_r + 9'h001 : 9'h000;
        dis_r <= gate_i ? diode_len_i : dis_r - {7'h00, dis_r != 8'h00};
    end

    // a shorted resistor shows nothing; an open one jumps past every level
    assign ramp_w = gate_i && (mode_i != 2'h1);
    assign open_w = mode_i == 2'h2 && on_r >= 9'h002;
    assign cs_min_o = ramp_w && (on_r != 9'h000);
    assign cs_lim_lo_o = ramp_w && (on_r >= 9'h008 || open_w);
    assign cs_lim_hi_o = ramp_w && (on_r >= 9'h028 || open_w);
    assign cs_ocp_o = ramp_w && open_w;
    // a new cycle must not start while this is high
    assign diode_cond_o = !gate_i && dis_r != 8'h00;
endmodule

// [verification/led_driver_protection_control_tb.sv]
// self-checking bench for led driver switching and protection
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
fail_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module led_driver_protection_control_tb;
    import led_ctrl_pkg::*;
    // shortened startup timers, same order as the real ones
    localparam int HOLD = 20000;
    localparam int BLANK = 3000;
    localparam int CMC = 4000;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    cmp_s c = '0;
    cmp_s cmp_w;
    logic [7:0] code = 8'hFF;
    logic [7:0] comp = 8'h40;
    logic [1:0] mode = 2'h0;
    logic [7:0] dlen = 8'h10;
    logic gate_o, hv_o, cm_o, cl_o, otp_o;
    logic p_min, p_lo, p_hi, p_ocp, p_dio;
    fault_s fault_o;
    int fail_count = 0;
    int total_checks = 0;
    int seed = 32'he1be;
    int n, w, e;

    // clock, 50 ns period
    always #25 clk_i = ~clk_i;

    // stage levels replace the current and diode fields
    always_comb
    begin
        cmp_w = c;
        cmp_w.cs_min = p_min;
        cmp_w.cs_lim_lo = p_lo;
        cmp_w.cs_lim_hi = p_hi;
        cmp_w.cs_ocp = p_ocp;
        cmp_w.diode_cond = p_dio;
    end

    led_driver_protection_control #(.HOLD_CYCLES(HOLD),
        .SHORT_BLANK_CYCLES(BLANK), .CM_CYCLES(CMC)) DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmp_i(cmp_w),
        .output_sense_pin_i(code), .compensation_node_i(comp),
        .gate_o(gate_o), .hv_supply_o(hv_o), .current_mode_o(cm_o),
        .cl_low_o(cl_o), .otp_o(otp_o), .fault_o(fault_o));

    flyback_stage stage (.clk_i(clk_i), .gate_i(gate_o), .mode_i(mode),
        .diode_len_i(dlen), .cs_min_o(p_min), .cs_lim_lo_o(p_lo),
        .cs_lim_hi_o(p_hi), .cs_ocp_o(p_ocp), .diode_cond_o(p_dio));

    // advance k clocks, then settle just past the edge
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #2;
    endtask

    // wait for a gate level, bounded at 3000 clocks
    task automatic wait_gate(input logic v, output int k);
        k = 0;
        while (gate_o !== v && k < 3000)
        begin
            tick(1);
            k++;
        end
    endtask

    // let k pulses pass, ending just after a turn-off
    task automatic turns(input int k);
        int t;
        repeat (k)
        begin
            wait_gate(1'b1, t);
            wait_gate(1'b0, t);
        end
    endtask

    // brown out and power up again, restarting the timers
    task automatic cycle_supply();
        c.vdd_on = 1'b0;
        c.vdd_off = 1'b1;
        tick(2);
        c.vdd_off = 1'b0;
        c.vdd_on = 1'b1;
        tick(1);
    endtask

    task automatic results();
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        tick(4);
        `CHK("gate_rst", 1'b0, gate_o)
        `CHK("hv_rst", 1'b1, hv_o)
        `CHK("fault_rst", 4'h0, fault_o)
        sys_rst_i = 1'b0;
        tick(600);
        `CHK("gate_uvlo", 1'b0, gate_o)
        // current mode: high limit, then low limit
        cycle_supply();
        wait_gate(1'b1, n);
        `CHK("first_on", 1'b1, n < 300)
        wait_gate(1'b0, w);
        `CHK("ton_hi", 1'b1, w >= 40 && w <= 43)
        c.osense_low = 1'b1;
        tick(1);
        `CHK("cl_low", 1'b1, cl_o)
        turns(1);
        wait_gate(1'b1, n);
        wait_gate(1'b0, w);
        `CHK("ton_lo", 1'b1, w >= 8 && w <= 11)
        c.osense_low = 1'b0;
        // random codes; settle one pulse, then time a period
        repeat (3)
        begin
            code = 8'h80 | 8'($random(seed));
            dlen = 8'($random(seed)) & 8'h3F;
            turns(1);
            wait_gate(1'b1, n);
            wait_gate(1'b0, w);
            wait_gate(1'b1, n);
            e = 65536 / code;
            `CHK("period", 1'b1, n + w >= e - 1 && n + w <= e + 3)
        end
        code = 8'hFF;
        dlen = 8'h10;
        // supply hold, mode change, voltage-mode on-time
        cycle_supply();
        c.vdd_hold_hi = 1'b1;
        tick(2);
        `CHK("hv_hi", 1'b0, hv_o)
        c.vdd_hold_hi = 1'b0;
        c.vdd_hold_lo = 1'b1;
        tick(2);
        `CHK("hv_lo", 1'b1, hv_o)
        c.vdd_hold_lo = 1'b0;
        tick(CMC - 30);
        `CHK("cm_on", 1'b1, cm_o)
        tick(40);
        `CHK("cm_off", 1'b0, cm_o)
        repeat (2)
        begin
            // kept under the 1.0 V limit point so on-time ends on comp
            comp = 8'h08 + (8'($random(seed)) & 8'h1F);
            turns(1);
            wait_gate(1'b1, n);
            wait_gate(1'b0, w);
            `CHK("ton_v", 1'b1, w >= comp && w <= comp + 2)
        end
        // long diode conduction pushes the turn-on past the period
        dlen = 8'hFF;
        turns(1);
        wait_gate(1'b1, n);
        `CHK("bcm", 1'b1, n >= 255 && n <= 259)
        dlen = 8'h10;
        tick(HOLD);
        `CHK("hv_end", 1'b0, hv_o)
        // short led: blanked first, then a broken run, then four
        cycle_supply();
        c.osense_low = 1'b1;
        tick(BLANK - 300);
        `CHK("short_blank", 1'b0, fault_o.short_led_protect)
        c.osense_low = 1'b0;
        turns(2);
        c.osense_low = 1'b1;
        turns(3);
        c.osense_low = 1'b0;
        turns(1);
        c.osense_low = 1'b1;
        turns(3);
        `CHK("short_3", 1'b0, fault_o.short_led_protect)
        tick(600);
        `CHK("short_4", 1'b1, fault_o.short_led_protect)
        `CHK("short_gate", 1'b0, gate_o)
        c.osense_low = 1'b0;
        // open sense resistor trips ocp; gate stays off
        mode = 2'h2;
        cycle_supply();
        `CHK("clr", 4'h0, fault_o)
        wait_gate(1'b1, n);
        tick(4);
        `CHK("ocp_gate", 1'b0, gate_o)
        `CHK("ocp", 1'b1, fault_o.ocp)
        wait_gate(1'b1, n);
        `CHK("latch", 1'b1, n >= 3000)
        // shorted resistor in the first cycle
        mode = 2'h1;
        cycle_supply();
        turns(1);
        tick(2);
        `CHK("rshort1", 1'b1, fault_o.sense_resistor_short_protect)
        // voltage-mode short with line above 60%
        mode = 2'h0;
        cycle_supply();
        c.vin_60 = 1'b1;
        tick(CMC + 600);
        `CHK("rshort_ok", 1'b0, fault_o.sense_resistor_short_protect)
        turns(1);
        mode = 2'h1;
        turns(1);
        tick(2);
        `CHK("rshort2", 1'b1, fault_o.sense_resistor_short_protect)
        c.vin_60 = 1'b0;
        mode = 2'h0;
        // supply then output-sense over-voltage in off-time
        for (int i = 0; i < 2; i++)
        begin
            cycle_supply();
            turns(1);
            c.vdd_ovp = (i == 0);
            c.osense_ovp = (i == 1);
            tick(3);
            `CHK("ovp", 1'b1, fault_o.ovp)
            c.vdd_ovp = 1'b0;
            c.osense_ovp = 1'b0;
        end
        // thermal hold and resume
        cycle_supply();
        turns(1);
        c.temp_hot = 1'b1;
        tick(2);
        c.temp_hot = 1'b0;
        `CHK("otp", 1'b1, otp_o)
        wait_gate(1'b1, n);
        `CHK("otp_hold", 1'b1, n >= 3000)
        c.temp_cool = 1'b1;
        tick(2);
        c.temp_cool = 1'b0;
        wait_gate(1'b1, n);
        `CHK("otp_go", 1'b1, otp_o === 1'b0 && n < 600)
        results();
    end

    // cut a hang short well beyond the expected run length
    initial
    begin
        #(100000 * 50);
        fail_count++;
        results();
    end
endmodule
